// File: inc/duty_pkg.sv
package duty_pkg;
  // register indices seen by the programmer command port
  localparam logic [2:0] REG_DUTY_OFFSET   = 3'h0;
  localparam logic [2:0] REG_LOWER_LIMIT   = 3'h1;
  localparam logic [2:0] REG_UPPER_LIMIT   = 3'h2;
  localparam logic [2:0] REG_DUTY_GAIN     = 3'h3;
  localparam logic [2:0] REG_LOCK          = 3'h4;
  localparam logic [2:0] REG_FIELD_SAMPLE  = 3'h5;
  // field widths
  localparam int OFFSET_W = 11;  // signed, 1024 = 100 %
  localparam int LIMIT_W  = 11;  // unsigned, 2048 = 100 %
  localparam int LOWER_W  = 10;  // 0..50 %
  localparam int GAIN_W   = 14;  // signed, 2048 = gain 1
  localparam int SAMPLE_W = 14;  // signed field sample
  localparam int DUTY_W   = 11;  // output duty, 2048 = 100 %
  localparam int DATA_W   = 16;
  // full scale constants
  localparam int DUTY_FULL    = 2048;  // 100 % in duty units
  localparam int OFFSET_SHIFT = 1;     // offset lsb is two duty lsb
  localparam int GAIN_SHIFT   = 11;    // gain 1 is 2048
  localparam int SAMPLE_SHIFT = 11;    // 2048 samples give 100 %
  // reset values
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 11'h000;
  localparam logic [LOWER_W-1:0]  LOWER_RST  = 10'h000;
  localparam logic [LIMIT_W-1:0]  UPPER_RST  = 11'h7FF;
  localparam logic [GAIN_W-1:0]   GAIN_RST   = 14'h0800;
  // mirror of the register cells, one word per index
  localparam int MEM_DEPTH = 8;
  localparam int MEM_AW    = 3;
endpackage

// File: design/setting_store.sv
// small register-file memory with registered read data
module setting_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             ref_clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_ff [DEPTH];  // no reset: contents are shadows

  // write port
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge ref_clk_i) begin
    rdata_o <= mem_ff[raddr_i];
  end
endmodule

// File: design/duty_offset_clamp_lock.sv
// Behaviour
// R1 - add signed duty offset to scaled sample
// R2 - negative offset caps duty at offset+100%
// R3 - clamp duty below at lower limit
// R4 - clamp duty above at upper limit
// R5 - lock in force ignores all commands
// R6 - lock acts only after power cycle
// R7 - lock bit can never be cleared
// R8 - raw 14-bit field sample is readable
// R9 - settings rewritable any number of times
// R10 - programmer uses same settings per application
// R11 - programmer computes gain, offset from samples
// R12 - calibration duties within limits, 70% apart
// R13 - multiply, add offset, clamp, drive duty
// R14 - gain one: 2048 samples give 100%
module duty_offset_clamp_lock #(
  parameter int PWM_PERIOD = 2048  // duty counter period in ticks
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          lock_nv_i,
  input  wire logic                          sample_valid_i,
  input  wire logic [duty_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic                          cmd_valid_i,
  input  wire logic                          cmd_write_i,
  input  wire logic [2:0]                    cmd_addr_i,
  input  wire logic [duty_pkg::DATA_W-1:0]   cmd_data_i,
  output logic                               rsp_valid_o,
  output logic      [duty_pkg::DATA_W-1:0]   rsp_data_o,
  output logic                               lock_set_o,
  output logic                               locked_o,
  output logic      [duty_pkg::DUTY_W-1:0]   duty_o,
  output logic                               pwm_o
);
  localparam int ACC_W = 32;  // wide signed work width
  localparam int DUTY_W = duty_pkg::DUTY_W;  // duty cast width

  // live settings
  logic signed [duty_pkg::OFFSET_W-1:0] offset_ff;   // signed offset
  logic [duty_pkg::LOWER_W-1:0]         lower_ff;    // lower clamp
  logic [duty_pkg::LIMIT_W-1:0]         upper_ff;    // upper clamp
  logic signed [duty_pkg::GAIN_W-1:0]   gain_ff;     // signed gain
  logic [duty_pkg::SAMPLE_W-1:0]        sample_ff;   // raw sample
  logic                                 lock_set_ff; // lock cell
  logic                                 locked_ff;   // lock in force
  logic                                 rd_pend_ff;  // read in flight
  logic [duty_pkg::DUTY_W-1:0]          duty_ff;     // clamped duty
  logic [duty_pkg::DUTY_W-1:0]          pwm_cnt_ff;  // pwm counter
  logic                                 pwm_ff;      // pwm level
  logic [duty_pkg::DATA_W-1:0]          store_rdata; // shadow read
  logic [2:0]                           rd_addr_ff;  // read index
  logic                                 cmd_ok;      // command taken
  logic signed [ACC_W-1:0]              nxt_duty;    // unclamped sum
  logic signed [ACC_W-1:0]              duty_hi;     // effective cap
  logic [3:0]                           wr_seen_ff;  // written since reset
  logic                                 boot_ff;     // power-up edge

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,  // normal pwm output
    ST_READ = 2'b01   // answering a read
  } cmd_state_e;
  cmd_state_e state_ff;

  // clamp helper shared by both ends of the range
  function automatic logic signed [ACC_W-1:0] clamp_fn(
    input logic signed [ACC_W-1:0] val,
    input logic signed [ACC_W-1:0] lo,
    input logic signed [ACC_W-1:0] hi
  );
    logic signed [ACC_W-1:0] r;
    r = val;
    if (r > hi) begin
      r = hi;
    end
    if (r < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // reset value of a setting, for reads before its first write
  function automatic logic [duty_pkg::DATA_W-1:0] reset_word(
    input logic [1:0] idx
  );
    logic [duty_pkg::DATA_W-1:0] w;
    case (idx)
      2'h0:    w = 16'(duty_pkg::OFFSET_RST);
      2'h1:    w = 16'(duty_pkg::LOWER_RST);
      2'h2:    w = 16'(duty_pkg::UPPER_RST);
      default: w = 16'(duty_pkg::GAIN_RST);
    endcase
    return w;
  endfunction

  // commands are dead once the lock is in force
  assign cmd_ok = cmd_valid_i && !locked_ff;  // [R5]

  // lock state: the stored cell is sampled once, just after power-up
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      locked_ff <= 1'b0;
      boot_ff   <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
      if (boot_ff) begin
        // a cell set during this run waits for the next power cycle
        locked_ff <= lock_nv_i;  // [R6]
      end
    end
  end

  // lock cell: write-one-to-set, only reset clears it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_set_ff <= 1'b0;
    end else if (lock_nv_i) begin
      lock_set_ff <= 1'b1;  // [R7]
    end else if (cmd_ok && cmd_write_i && cmd_addr_i == duty_pkg::REG_LOCK
                 && cmd_data_i[0]) begin
      lock_set_ff <= 1'b1;  // [R7]
    end
  end

  // programmable settings, rewritable until locked
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_seen_ff <= '0;
      offset_ff <= duty_pkg::OFFSET_RST;
      lower_ff  <= duty_pkg::LOWER_RST;
      upper_ff  <= duty_pkg::UPPER_RST;
      gain_ff   <= duty_pkg::GAIN_RST;
    end else if (cmd_ok && cmd_write_i) begin
      if (!cmd_addr_i[2]) begin
        wr_seen_ff[cmd_addr_i[1:0]] <= 1'b1;  // store cell now valid
      end
      case (cmd_addr_i)  // each write replaces the old value [R9]
        duty_pkg::REG_DUTY_OFFSET:
          offset_ff <= cmd_data_i[duty_pkg::OFFSET_W-1:0];
        duty_pkg::REG_LOWER_LIMIT:
          lower_ff <= cmd_data_i[duty_pkg::LOWER_W-1:0];
        duty_pkg::REG_UPPER_LIMIT:
          upper_ff <= cmd_data_i[duty_pkg::LIMIT_W-1:0];
        duty_pkg::REG_DUTY_GAIN:
          gain_ff <= cmd_data_i[duty_pkg::GAIN_W-1:0];
        default: ;  // lock and sample handled elsewhere
      endcase
    end
  end

  // raw field sample capture, before any processing
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_ff <= '0;
    end else if (sample_valid_i) begin
      sample_ff <= sample_i;  // [R8]
    end
  end

  // shadow copy keeps a plain readback path for the settings
  setting_store #(
    .WIDTH (duty_pkg::DATA_W),
    .DEPTH (duty_pkg::MEM_DEPTH),
    .AW    (duty_pkg::MEM_AW)
  ) u_store (
    .ref_clk_i (ref_clk_i),
    .we_i      (cmd_ok && cmd_write_i),
    .waddr_i   (cmd_addr_i),
    .wdata_i   (cmd_data_i),
    .raddr_i   (cmd_addr_i),
    .rdata_o   (store_rdata)
  );

  // datapath: gain times sample, shift, plus offset
  always_comb begin
    logic signed [ACC_W-1:0] prod;
    prod = ACC_W'(signed'(sample_ff)) * ACC_W'(gain_ff);  // [R13]
    prod = prod >>> duty_pkg::GAIN_SHIFT;  // 2048 samples = 100 % [R14]
    nxt_duty = prod
      + (ACC_W'(offset_ff) <<< duty_pkg::OFFSET_SHIFT);  // [R1]
  end

  // upper bound: the limit, or offset+100% when the offset is negative and that is lower
  always_comb begin
    logic signed [ACC_W-1:0] cap;
    // a negative offset leaves less than full scale above it
    cap = (ACC_W'(offset_ff) <<< duty_pkg::OFFSET_SHIFT)
          + ACC_W'(duty_pkg::DUTY_FULL - 1);
    duty_hi = ACC_W'(upper_ff);  // [R4]
    if (offset_ff < 0 && cap < duty_hi) begin
      duty_hi = cap;  // [R2]
    end
  end

  // clamped duty register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      duty_ff <= '0;
    end else begin
      duty_ff <= DUTY_W'(clamp_fn(nxt_duty, ACC_W'(lower_ff), duty_hi));  // [R3]
    end
  end

  // command state: pwm output held low while a read is answered, counter keeps running
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff   <= ST_RUN;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= '0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (cmd_ok && !cmd_write_i) begin  // reads refused when locked [R5]
            state_ff   <= ST_READ;
            rd_pend_ff <= 1'b1;
            rd_addr_ff <= cmd_addr_i;
          end
        end
        ST_READ: begin
          state_ff   <= ST_RUN;
          rd_pend_ff <= 1'b0;
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  // read answer mux, registered
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
    end else begin
      rsp_valid_o <= rd_pend_ff;
      if (rd_pend_ff) begin
        case (rd_addr_ff)
          duty_pkg::REG_FIELD_SAMPLE:
            rsp_data_o <= {{(duty_pkg::DATA_W-duty_pkg::SAMPLE_W)
                           {sample_ff[duty_pkg::SAMPLE_W-1]}}, sample_ff};
          duty_pkg::REG_LOCK:
            rsp_data_o <= {15'h0000, lock_set_ff};
          duty_pkg::REG_DUTY_OFFSET,
          duty_pkg::REG_LOWER_LIMIT,
          duty_pkg::REG_UPPER_LIMIT,
          duty_pkg::REG_DUTY_GAIN:
            // never-written cells hold junk: show the reset value instead
            rsp_data_o <= wr_seen_ff[rd_addr_ff[1:0]] ? store_rdata
                          : reset_word(rd_addr_ff[1:0]);
          default:
            rsp_data_o <= 16'h0000;  // unmapped reads as zero
        endcase
      end
    end
  end

  // pwm counter and output; forced low during a read answer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_cnt_ff <= '0;
      pwm_ff     <= 1'b0;
    end else begin
      pwm_cnt_ff <= (int'(pwm_cnt_ff) == PWM_PERIOD - 1) ? '0
                                                        : pwm_cnt_ff + 1'b1;
      pwm_ff <= (state_ff == ST_RUN) && (pwm_cnt_ff < duty_ff);  // [R13]
    end
  end

  assign duty_o     = duty_ff;
  assign pwm_o      = pwm_ff;
  assign lock_set_o = lock_set_ff;
  assign locked_o   = locked_ff;

  // assertions
  property p_lock_blocks;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      locked_ff && cmd_valid_i && !cmd_write_i |=> !rd_pend_ff;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)  // [R5]
    else $error("read accepted while locked");

  property p_lock_sticky;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      lock_set_ff |=> lock_set_ff;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)  // [R7]
    else $error("lock cell cleared");

  property p_lock_delayed;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !locked_ff && !(boot_ff && lock_nv_i) |=> !locked_ff;
  endproperty
  a_lock_delayed: assert property (p_lock_delayed)  // [R6]
    else $error("lock acted without power cycle");

  property p_upper;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      ##1 (lower_ff <= upper_ff) && $stable(upper_ff) && $stable(lower_ff)
      |-> duty_ff <= upper_ff;
  endproperty
  a_upper: assert property (p_upper)  // [R4]
    else $error("duty above upper limit");

  property p_lower;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $stable(lower_ff) && $past(lower_ff) <= $past(upper_ff)
      |-> duty_ff >= lower_ff;
  endproperty
  a_lower: assert property (p_lower)  // [R3]
    else $error("duty below lower limit");

  property p_write;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      cmd_ok && cmd_write_i && cmd_addr_i == duty_pkg::REG_DUTY_GAIN
      |=> gain_ff == $past(cmd_data_i[duty_pkg::GAIN_W-1:0]);
  endproperty
  a_write: assert property (p_write)  // [R9]
    else $error("gain write lost");

  property p_read_time;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_ff == ST_RUN && cmd_ok && !cmd_write_i |-> ##2 rsp_valid_o;
  endproperty
  a_read_time: assert property (p_read_time)  // [R8]
    else $error("read answer late");

  property p_pwm_quiet;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_ff == ST_READ |=> !pwm_ff;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet)  // [R13]
    else $error("pwm active during read");

  c_read:  cover property (@(posedge ref_clk_i) rsp_valid_o);
  c_lock:  cover property (@(posedge ref_clk_i) locked_ff);
  c_clamp: cover property (@(posedge ref_clk_i)
                           duty_ff == upper_ff && upper_ff != 0);
endmodule

// File: test/prog_model.sv
// command side of the supply-modulation programmer
module prog_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [15:0] rsp_data_i,
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [2:0]       cmd_addr_o,
  output logic [15:0]      cmd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_addr_o  = 3'h0;
    cmd_data_o  = 16'h0000;
  end
  // one whole word per command, taken at the next edge
  task automatic issue(input logic w, input logic [2:0] a,
                       input logic [15:0] d);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_addr_o  <= a;
    cmd_data_o  <= d;
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_data_o  <= ~d;  // stale word hidden once released
  endtask
  // bounded wait also covers a refused read
  task automatic rd(input logic [2:0] a, output logic got,
                    output logic [15:0] q);
    got = 1'b0;
    q   = 16'h0000;
    issue(1'b0, a, 16'h0000);
    for (int n = 0; n < 4 && !got; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (rsp_valid_i === 1'b1) begin
        got = 1'b1;
        q   = rsp_data_i;
      end
    end
  endtask
endmodule

// File: test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i;
  logic        reset_n_i;
  logic        lock_nv_i;
  logic        sample_valid_i;
  logic [13:0] sample_i;
  logic        cmd_valid;
  logic        cmd_write;
  logic [2:0]  cmd_addr;
  logic [15:0] cmd_data;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        lock_set;
  logic        locked;
  logic [10:0] duty;
  logic        pwm;
  int          num_errors;
  int          compares;

  // clock only; time-zero inputs are set in the main sequence
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // full period: one pwm tick per duty unit
  duty_offset_clamp_lock duty_offset_clamp_lock_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .lock_nv_i(lock_nv_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .lock_set_o(lock_set), .locked_o(locked), .duty_o(duty), .pwm_o(pwm));
  prog_model prog_model_inst (
    .ref_clk_i(ref_clk_i), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data));

  // one compare for every kind of value
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reference duty; samples chosen so the shift is exact
  function automatic logic [10:0] exp_duty(input int s, g, o, lo, hi);
    int v;
    v = ((s * g) >>> 11) + 2 * o;
    if (o < 0 && v > 2 * o + 2047) v = 2 * o + 2047;
    if (v > hi) v = hi;
    if (v < lo) v = lo;
    return v[10:0];
  endfunction
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    prog_model_inst.issue(1'b1, a, d);
  endtask
  task automatic cfg(input int o, lo, hi, g);
    wr(duty_pkg::REG_DUTY_OFFSET, 16'(o));
    wr(duty_pkg::REG_LOWER_LIMIT, 16'(lo));
    wr(duty_pkg::REG_UPPER_LIMIT, 16'(hi));
    wr(duty_pkg::REG_DUTY_GAIN, 16'(g));
  endtask
  // capture one sample, then let the pipeline settle
  task automatic put(input int s);
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b1;
    sample_i       <= 14'(s);
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1;
  endtask
  // reset stands in for a power cycle
  task automatic pwr(input logic nv);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    lock_nv_i <= nv;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic t_rewrite();
    logic g; logic [15:0] q;
    wr(duty_pkg::REG_DUTY_OFFSET, 16'h0155);
    wr(duty_pkg::REG_DUTY_OFFSET, 16'h02AA);
    prog_model_inst.rd(duty_pkg::REG_DUTY_OFFSET, g, q);
    chk("offset readback", 16'h02AA, q & 16'h07FF);
    prog_model_inst.rd(duty_pkg::REG_UPPER_LIMIT, g, q);
    chk("upper default", 16'h07FF, q & 16'h07FF);
    $display("test rewrite done");
  endtask
  task automatic t_path();
    int n;
    cfg(256, 0, 2047, 2048);
    put(0);
    chk("duty zero sample", exp_duty(0, 2048, 256, 0, 2047), duty);
    put(512);
    chk("duty gain one", exp_duty(512, 2048, 256, 0, 2047), duty);
    // one full pwm period: high ticks equal the duty
    n = 0;
    repeat (2048) begin
      @(posedge ref_clk_i);
      #1;
      if (pwm === 1'b1) n++;
    end
    chk("pwm high ticks", exp_duty(512, 2048, 256, 0, 2047), 16'(n));
    wr(duty_pkg::REG_DUTY_GAIN, 16'h0400);
    put(512);
    chk("duty gain half", exp_duty(512, 1024, 256, 0, 2047), duty);
    $display("test path done");
  endtask
  task automatic t_clamp();
    cfg(0, 256, 1536, 2048);
    put(4096);
    chk("duty upper", exp_duty(4096, 2048, 0, 256, 1536), duty);
    put(-512);
    chk("duty lower", exp_duty(-512, 2048, 0, 256, 1536), duty);
    cfg(-256, 0, 2047, 2048);
    put(4096);
    chk("duty neg cap", exp_duty(4096, 2048, -256, 0, 2047), duty);
    $display("test clamp done");
  endtask
  task automatic t_sample();
    logic g; logic [15:0] q;
    put(-5);
    prog_model_inst.rd(duty_pkg::REG_FIELD_SAMPLE, g, q);
    chk("sample read", 16'hFFFB, q);
    $display("test sample done");
  endtask
  // two-point calibration as a programmer would run it
  task automatic t_cal();
    logic g;
    logic [15:0] q;
    int s1;
    int s2;
    int gn;
    int of;
    cfg(0, 0, 2047, 2048);
    put(-1024);
    prog_model_inst.rd(duty_pkg::REG_FIELD_SAMPLE, g, q);
    chk("cal sample one", 16'hFC00, q);
    s1 = int'(signed'(q));
    put(1024);
    prog_model_inst.rd(duty_pkg::REG_FIELD_SAMPLE, g, q);
    chk("cal sample two", 16'h0400, q);
    s2 = int'(signed'(q));
    // targets 12.5 % and 87.5 %: inside the limits, 75 % apart
    gn = (1792 - 256) * 2048 / (s2 - s1);
    of = (256 - s1 * gn / 2048) / 2;
    wr(duty_pkg::REG_DUTY_GAIN, 16'(gn));
    wr(duty_pkg::REG_DUTY_OFFSET, 16'(of));
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("cal point two", exp_duty(1024, 1536, 512, 0, 2047), duty);
    put(-1024);
    chk("cal point one", exp_duty(-1024, 1536, 512, 0, 2047), duty);
    $display("test cal done");
  endtask
  task automatic t_lock();
    logic g; logic [15:0] q;
    wr(duty_pkg::REG_LOCK, 16'h0001);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("lock cell", 16'h0001, {15'h0, lock_set});
    chk("locked early", 16'h0000, {15'h0, locked});
    prog_model_inst.rd(duty_pkg::REG_DUTY_OFFSET, g, q);
    chk("read before cycle", 16'h0001, {15'h0, g});
    pwr(lock_set);
    chk("locked after cycle", 16'h0001, {15'h0, locked});
    cfg(256, 0, 2047, 2048);
    put(0);
    chk("duty locked", exp_duty(0, 2048, 0, 0, 2047), duty);
    prog_model_inst.rd(duty_pkg::REG_FIELD_SAMPLE, g, q);
    chk("read refused", 16'h0000, {15'h0, g});
    wr(duty_pkg::REG_LOCK, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("lock kept", 16'h0001, {15'h0, lock_set});
    $display("test lock done");
  endtask

  // watchdog well beyond the few thousand cycles used
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    num_errors     = 0;
    compares       = 0;
    reset_n_i      = 1'b0;
    lock_nv_i      = 1'b0;
    sample_valid_i = 1'b0;
    sample_i       = 14'h0000;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_rewrite();
    t_path();
    t_clamp();
    t_sample();
    t_cal();
    t_lock();
    final_report();
  end
endmodule
